// ---- rtl/bts_consts.svh ----
// register offsets, field positions and reset values of the trace sequencer
`ifndef BTS_CONSTS_SVH
`define BTS_CONSTS_SVH
`define REG_CTRL      8'h00
`define REG_DELAY     8'h01
`define REG_MAXTRACE  8'h02
`define REG_ENDSTATE  8'h03
`define REG_LOOP      8'h04
`define REG_TIMEOUT   8'h05
`define REG_TIMER     8'h06
`define REG_TRPTR     8'h07
`define REG_TRSAMPLE  8'h08
`define REG_TRTIME    8'h09
`define REG_STATE0    8'h10
`define REG_ACT0      8'h40
`define CTRL_RESTART  0
`define CTRL_CLRERR   1
`define CFG_ADDRONLY  0
`define CFG_EXTTRACE  1
`define CFG_EVLSB     16
`define RST_EVINIT    16'h0001
`define RST_DELAY     11'h000
`define RST_MAXTRACE  11'h000
`define RST_ENDSTATE  2'h0
`define RST_LOOP      16'h0001
`define RST_TIMEOUT   32'h0000_0000
`define TRACE_LAST    11'h7fe
`define FULL_SLOTS    3'h4
`define DATA_SLOTS    3'h2
`endif

// ---- rtl/bts_pkg.sv ----
// types shared by the trace sequencer and its users
package bts_pkg;
	typedef enum logic [1:0] {KIND_IDLE, KIND_FETCH, KIND_READ, KIND_WRITE} busKind_e;
	typedef enum logic [1:0] {ACT_NONE, ACT_TRACE, ACT_EVENT} actKind_e;
	typedef enum logic [2:0] {CYC_ALL, CYC_NONE, CYC_RD, CYC_WR, CYC_RDWR, CYC_FETCH,
		CYC_FETCHRD, CYC_FETCHWR} cycSel_e;
	typedef enum logic [1:0] {WHY_NONE, WHY_BREAK, WHY_FULL, WHY_TIMEOUT} haltWhy_e;
	typedef struct packed {
		logic     valid;
		busKind_e kind;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [7:0]  probe;
	} busCycle_s;
	typedef struct packed {
		actKind_e    kind;
		cycSel_e     cyc;
		logic [15:0] aVal;
		logic [15:0] aMask;
		logic [7:0]  dVal;
		logic [7:0]  dMask;
		logic [7:0]  pVal;
		logic [7:0]  pMask;
	} action_s;
	typedef struct packed {
		logic        addrOnly;
		logic        extTrace;
		logic [15:0] evInit;
	} stateCfg_s;
	typedef struct packed {
		busKind_e    kind;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [31:0] stamp;
	} traceSample_s;
endpackage : bts_pkg

// ---- rtl/bus_trace_breakpoint_sequencer.sv ----
// trace and hardware breakpoint sequencer watching the target cpu bus
// Overview of operation
// - address-only state ignores data, four actions
// - address-plus-data allows two actions; default mode
// - rejected mode switch with too many actions flags error
// - each state selects normal or extended trace
// - normal trace needs all qualifiers met together
// - extended trace qualifies fetch, then cycles follow
// - event counter expiry advances or completes sequence
// - event count 0 to ffff, default 1, 0 disables
// - breakpoint waits delay count samples; zero immediate
// - delay count ranges 0 to 7ff
// - delay advances only on trace samples
// - breakpoint and trace-full halts only at instruction boundary
// - buffer holds 7ff samples, wraps when unlimited
// - max trace reached halts with trace-full reason unless a breakpoint is also pending
// - max trace ranges 0 to 7ff, default 0
// - end state 0 to 3; breakpoint only there
// - end state 0 default; no advance then
// - loop count repeats sequence, final expiry arms breakpoint
// - loop count ranges 0 to ffff
// - free timer starts at reset, stamps samples
// - nonzero time-out equal to timer halts at once
// - mask ANDs both observed and qualifier values
// - cycle qualifier selects eight cycle kind sets
`timescale 1ns/100ps
`default_nettype none
`include "bts_consts.svh"
module bus_trace_breakpoint_sequencer
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire bts_pkg::busCycle_s busIn,
	input  wire logic [7:0]       regAddr,
	input  wire logic [31:0]      regWrData,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic [31:0]           regRdData,
	output logic                  haltReq,
	output bts_pkg::haltWhy_e     haltWhy
);
	import bts_pkg::*;

	typedef enum {PH_ACTIVE, PH_DELAY, PH_HALTED} phase_e;

	// cycle qualifier decode
	function automatic logic cycOk(cycSel_e s, busKind_e k);
		logic f;
		logic r;
		logic w;
		f = (k == KIND_FETCH);
		r = (k == KIND_READ);
		w = (k == KIND_WRITE);
		case (s)
			CYC_ALL:     cycOk = 1'b1;
			CYC_NONE:    cycOk = 1'b0;
			CYC_RD:      cycOk = r;
			CYC_WR:      cycOk = w;
			CYC_RDWR:    cycOk = r | w;
			CYC_FETCH:   cycOk = f;
			CYC_FETCHRD: cycOk = f | r;
			CYC_FETCHWR: cycOk = f | w;
			default:     cycOk = 1'b0;
		endcase
	endfunction : cycOk

	// masked value compare; data skipped in address-only states
	function automatic logic qualOk(action_s a, busCycle_s b, logic addrOnly);
		logic ao;
		logic dOk;
		logic po;
		ao  = (b.addr & a.aMask) == (a.aVal & a.aMask);
		dOk = addrOnly | ((b.data & a.dMask) == (a.dVal & a.dMask));
		po  = (b.probe & a.pMask) == (a.pVal & a.pMask);
		qualOk = ao & dOk & po;
	endfunction : qualOk

	// configuration
	stateCfg_s    stCfg_ff [4];
	stateCfg_s    nxt_stCfg [4];
	action_s      act_ff [16];
	action_s      nxt_act [16];
	logic [10:0]  delay_ff, nxt_delay;
	logic [10:0]  maxTrace_ff, nxt_maxTrace;
	logic [1:0]   endState_ff, nxt_endState;
	logic [15:0]  loop_ff, nxt_loop;
	logic [31:0]  timeout_ff, nxt_timeout;
	logic         modeErr_ff, nxt_modeErr;
	logic [10:0]  rdIdx_ff, nxt_rdIdx;
	logic         restart;
	logic         errSet;

	// sequencer state
	phase_e       phase_ff, nxt_phase;
	logic [1:0]   state_ff, nxt_state;
	logic [15:0]  evCnt_ff, nxt_evCnt;
	logic [15:0]  loopCnt_ff, nxt_loopCnt;
	logic [10:0]  delayCnt_ff, nxt_delayCnt;
	logic [10:0]  traceCnt_ff, nxt_traceCnt;
	logic [10:0]  wrPtr_ff, nxt_wrPtr;
	logic [31:0]  timer_ff, nxt_timer;
	logic         pendBrk_ff, nxt_pendBrk;
	logic         pendFull_ff, nxt_pendFull;
	haltWhy_e     why_ff, nxt_why;
	logic [3:0]   instrQual_ff, nxt_instrQual;

	traceSample_s traceMem [2048];
	traceSample_s rdSample_ff;
	logic [31:0]  rdData_ff, nxt_rdData;

	logic [3:0]   slotLive, trHit, evHit;
	logic         traceHit, eventHit, running, boundary;
	stateCfg_s    cur;
	logic [1:0]   stepState;

	assign restart = regWr && regAddr == `REG_CTRL && regWrData[`CTRL_RESTART];
	assign cur     = stCfg_ff[state_ff];
	assign running = busIn.valid && phase_ff != PH_HALTED;
	assign boundary = busIn.valid && busIn.kind == KIND_FETCH;

	// per-slot qualification of the current state
	genvar k;
	generate
		for (k = 0; k < 4; k++)
		begin : g_slot
			action_s a;
			logic    cOk, qOk, tq;
			assign a   = act_ff[{state_ff, 2'(k)}];
			assign slotLive[k] = (cur.addrOnly || k < `DATA_SLOTS) && running;
			assign cOk = cycOk(a.cyc, busIn.kind);
			assign qOk = qualOk(a, busIn, cur.addrOnly);
			// extended mode: only the fetch is qualified, later cycles ride on it
			assign tq  = cur.extTrace ? (busIn.kind == KIND_FETCH ? qOk : instrQual_ff[k])
				: qOk;
			assign trHit[k] = slotLive[k] && a.kind == ACT_TRACE && cOk && tq;
			assign evHit[k] = slotLive[k] && a.kind == ACT_EVENT && cOk && qOk;
			// one driver per bit; a fetch decides for the cycles that follow it
			assign nxt_instrQual[k] = restart ? 1'b0 : (boundary ? qOk : instrQual_ff[k]);
		end
	endgenerate
	assign traceHit = |trHit;
	assign eventHit = |evHit;
	assign stepState = state_ff + 2'h1;

	// register writes; mode changes checked against slot usage
	always_comb
	begin
		nxt_stCfg    = stCfg_ff;
		nxt_act      = act_ff;
		nxt_delay    = delay_ff;
		nxt_maxTrace = maxTrace_ff;
		nxt_endState = endState_ff;
		nxt_loop     = loop_ff;
		nxt_timeout  = timeout_ff;
		nxt_rdIdx    = rdIdx_ff;
		errSet       = 1'b0;
		if (regWr)
		begin
			case (regAddr)
				`REG_DELAY:    nxt_delay    = regWrData[10:0];
				`REG_MAXTRACE: nxt_maxTrace = regWrData[10:0];
				`REG_ENDSTATE: nxt_endState = regWrData[1:0];
				`REG_LOOP:     nxt_loop     = regWrData[15:0];
				`REG_TIMEOUT:  nxt_timeout  = regWrData;
				`REG_TRPTR:    nxt_rdIdx    = regWrData[10:0];
				default:
				begin
					if (regAddr[7:2] == 6'(`REG_STATE0 >> 2))
					begin
						// upper slots still in use forbid address-plus-data
						if (!regWrData[`CFG_ADDRONLY] && stCfg_ff[regAddr[1:0]].addrOnly
							&& (act_ff[{regAddr[1:0], 2'h2}].kind != ACT_NONE
							|| act_ff[{regAddr[1:0], 2'h3}].kind != ACT_NONE))
							errSet = 1'b1;
						else
						begin
							nxt_stCfg[regAddr[1:0]].addrOnly = regWrData[`CFG_ADDRONLY];
							nxt_stCfg[regAddr[1:0]].extTrace = regWrData[`CFG_EXTTRACE];
							nxt_stCfg[regAddr[1:0]].evInit =
								regWrData[`CFG_EVLSB +: 16];
						end
					end
					else if (regAddr[7:6] == 2'h1)
					begin
						case (regAddr[1:0])
							2'h0:
							begin
								// only two slots in address-plus-data states
								if (regAddr[3] && !stCfg_ff[regAddr[5:4]].addrOnly
									&& regWrData[1:0] != 2'h0)
									errSet = 1'b1;
								else
								begin
									nxt_act[regAddr[5:2]].kind = actKind_e'(regWrData[1:0]);
									nxt_act[regAddr[5:2]].cyc  = cycSel_e'(regWrData[4:2]);
								end
							end
							2'h1:
							begin
								nxt_act[regAddr[5:2]].aVal  = regWrData[15:0];
								nxt_act[regAddr[5:2]].aMask = regWrData[31:16];
							end
							2'h2:
							begin
								nxt_act[regAddr[5:2]].dVal  = regWrData[7:0];
								nxt_act[regAddr[5:2]].dMask = regWrData[15:8];
								nxt_act[regAddr[5:2]].pVal  = regWrData[23:16];
								nxt_act[regAddr[5:2]].pMask = regWrData[31:24];
							end
							default: ;
						endcase
					end
				end
			endcase
		end
		// a new error beats a clear in the same cycle
		nxt_modeErr = errSet | (modeErr_ff & ~(regWr && regAddr == `REG_CTRL
			&& regWrData[`CTRL_CLRERR]));
	end

	// configuration registers with documented defaults
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 4; i++)
				stCfg_ff[i] <= '{addrOnly: 1'b0, extTrace: 1'b0, evInit: `RST_EVINIT};
			for (int i = 0; i < 16; i++)
				act_ff[i] <= '0;
			delay_ff    <= `RST_DELAY;
			maxTrace_ff <= `RST_MAXTRACE;
			endState_ff <= `RST_ENDSTATE;
			loop_ff     <= `RST_LOOP;
			timeout_ff  <= `RST_TIMEOUT;
			modeErr_ff  <= 1'b0;
			rdIdx_ff    <= '0;
		end
		else
		begin
			stCfg_ff    <= nxt_stCfg;
			act_ff      <= nxt_act;
			delay_ff    <= nxt_delay;
			maxTrace_ff <= nxt_maxTrace;
			endState_ff <= nxt_endState;
			loop_ff     <= nxt_loop;
			timeout_ff  <= nxt_timeout;
			modeErr_ff  <= nxt_modeErr;
			rdIdx_ff    <= nxt_rdIdx;
		end
	end

	// sequencer: events, loops, delay, max trace, time-out
	always_comb
	begin
		nxt_phase    = phase_ff;
		nxt_state    = state_ff;
		nxt_evCnt    = evCnt_ff;
		nxt_loopCnt  = loopCnt_ff;
		nxt_delayCnt = delayCnt_ff;
		nxt_traceCnt = traceCnt_ff;
		nxt_wrPtr    = wrPtr_ff;
		nxt_pendBrk  = pendBrk_ff;
		nxt_pendFull = pendFull_ff;
		nxt_why      = why_ff;
		nxt_timer    = timer_ff + 32'h1;
		if (restart)
		begin
			nxt_phase    = PH_ACTIVE;
			nxt_state    = 2'h0;
			nxt_evCnt    = stCfg_ff[0].evInit;
			nxt_loopCnt  = loop_ff;
			nxt_delayCnt = '0;
			nxt_traceCnt = '0;
			nxt_wrPtr    = '0;
			nxt_pendBrk  = 1'b0;
			nxt_pendFull = 1'b0;
			nxt_why      = WHY_NONE;
			nxt_timer    = '0;
		end
		else if (phase_ff != PH_HALTED && timeout_ff != '0 && timer_ff == timeout_ff)
		begin
			nxt_phase = PH_HALTED;
			nxt_why   = WHY_TIMEOUT;
		end
		else if (running)
		begin
			if ((pendBrk_ff || pendFull_ff) && boundary)
			begin
				nxt_phase = PH_HALTED;
				nxt_why   = pendBrk_ff ? WHY_BREAK : WHY_FULL;
			end
			if (traceHit)
			begin
				// wrap overwrites the oldest sample
				nxt_wrPtr = (wrPtr_ff == `TRACE_LAST) ? 11'h0 : wrPtr_ff + 11'h1;
				if (traceCnt_ff != 11'h7ff)
					nxt_traceCnt = traceCnt_ff + 11'h1;
				if (maxTrace_ff != '0 && traceCnt_ff + 11'h1 == maxTrace_ff)
					nxt_pendFull = 1'b1;
				if (phase_ff == PH_DELAY && delayCnt_ff != '0)
				begin
					nxt_delayCnt = delayCnt_ff - 11'h1;
					if (delayCnt_ff == 11'h1)
						nxt_pendBrk = 1'b1;
				end
			end
			// zero count means this state never expires
			if (phase_ff == PH_ACTIVE && eventHit && evCnt_ff != '0)
			begin
				nxt_evCnt = evCnt_ff - 16'h1;
				if (evCnt_ff == 16'h1)
				begin
					if (state_ff != endState_ff)
					begin
						nxt_state = stepState;
						nxt_evCnt = stCfg_ff[stepState].evInit;
					end
					else if (loopCnt_ff > 16'h1)
					begin
						nxt_loopCnt = loopCnt_ff - 16'h1;
						nxt_state   = 2'h0;
						nxt_evCnt   = stCfg_ff[0].evInit;
					end
					else if (delay_ff == '0)
						nxt_pendBrk = 1'b1;
					else
					begin
						nxt_phase    = PH_DELAY;
						nxt_delayCnt = delay_ff;
					end
				end
			end
		end
	end

	// sequencer registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_ff     <= PH_ACTIVE;
			state_ff     <= 2'h0;
			evCnt_ff     <= `RST_EVINIT;
			loopCnt_ff   <= `RST_LOOP;
			delayCnt_ff  <= '0;
			traceCnt_ff  <= '0;
			wrPtr_ff     <= '0;
			timer_ff     <= '0;
			pendBrk_ff   <= 1'b0;
			pendFull_ff  <= 1'b0;
			why_ff       <= WHY_NONE;
			instrQual_ff <= '0;
		end
		else
		begin
			phase_ff     <= nxt_phase;
			state_ff     <= nxt_state;
			evCnt_ff     <= nxt_evCnt;
			loopCnt_ff   <= nxt_loopCnt;
			delayCnt_ff  <= nxt_delayCnt;
			traceCnt_ff  <= nxt_traceCnt;
			wrPtr_ff     <= nxt_wrPtr;
			timer_ff     <= nxt_timer;
			pendBrk_ff   <= nxt_pendBrk;
			pendFull_ff  <= nxt_pendFull;
			why_ff       <= nxt_why;
			instrQual_ff <= nxt_instrQual;
		end
	end

	// trace buffer; no reset so it maps onto block memory
	always_ff @(posedge clk)
	begin
		if (traceHit && !restart)
			traceMem[wrPtr_ff] <= '{kind: busIn.kind, addr: busIn.addr,
				data: busIn.data, stamp: timer_ff};
		rdSample_ff <= traceMem[rdIdx_ff];
	end

	// read mux, answer one cycle after the strobe
	always_comb
	begin
		nxt_rdData = '0;
		if (regRd)
		begin
			case (regAddr)
				`REG_CTRL:     nxt_rdData = {24'h0, 2'(phase_ff == PH_DELAY), state_ff,
					modeErr_ff, why_ff, phase_ff == PH_HALTED};
				`REG_DELAY:    nxt_rdData = {21'h0, delay_ff};
				`REG_MAXTRACE: nxt_rdData = {21'h0, maxTrace_ff};
				`REG_ENDSTATE: nxt_rdData = {30'h0, endState_ff};
				`REG_LOOP:     nxt_rdData = {16'h0, loop_ff};
				`REG_TIMEOUT:  nxt_rdData = timeout_ff;
				`REG_TIMER:    nxt_rdData = timer_ff;
				`REG_TRPTR:    nxt_rdData = {5'h0, traceCnt_ff, 5'h0, wrPtr_ff};
				default:
					if (regAddr[7:2] == 6'(`REG_STATE0 >> 2))
						nxt_rdData = {stCfg_ff[regAddr[1:0]].evInit, 14'h0,
							stCfg_ff[regAddr[1:0]].extTrace, stCfg_ff[regAddr[1:0]].addrOnly};
					else if (regAddr[7:6] == 2'h1 && regAddr[1:0] == 2'h0)
						nxt_rdData = {27'h0, act_ff[regAddr[5:2]].cyc, act_ff[regAddr[5:2]].kind};
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdData_ff <= '0;
		else
			rdData_ff <= nxt_rdData;
	end

	logic rdSampleSel_ff;
	logic rdTimeSel_ff;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdSampleSel_ff <= 1'b0;
			rdTimeSel_ff   <= 1'b0;
		end
		else
		begin
			rdSampleSel_ff <= regRd && regAddr == `REG_TRSAMPLE;
			rdTimeSel_ff   <= regRd && regAddr == `REG_TRTIME;
		end
	end

	// sample words come straight from the buffer read port
	assign regRdData = rdSampleSel_ff ? {6'h0, rdSample_ff.kind, rdSample_ff.data,
		rdSample_ff.addr} : rdTimeSel_ff ? rdSample_ff.stamp : rdData_ff;
	assign haltReq = phase_ff == PH_HALTED;
	assign haltWhy = why_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_timeHit;
		phase_ff != PH_HALTED && timeout_ff != '0 && timer_ff == timeout_ff && !restart;
	endsequence
	sequence s_halted(haltWhy_e w);
		haltReq && haltWhy == w;
	endsequence

	a_timeout_halt: assert property (s_timeHit |=> s_halted(WHY_TIMEOUT))
		else $error("time-out did not halt");
	a_halt_boundary: assert property ($rose(haltReq) && haltWhy != WHY_TIMEOUT
		|-> $past(boundary))
		else $error("halt off instruction boundary");
	a_full_reason: assert property (pendFull_ff && !pendBrk_ff && boundary && running
		&& !restart && !(timeout_ff != '0 && timer_ff == timeout_ff) |=> s_halted(WHY_FULL))
		else $error("trace full not reported");
	a_slot_limit: assert property (!cur.addrOnly |-> trHit[3:2] == 2'h0 && evHit[3:2] == 2'h0)
		else $error("upper slot active in data mode");
	a_break_endstate: assert property ($rose(pendBrk_ff) && phase_ff != PH_DELAY
		|-> $past(state_ff) == endState_ff)
		else $error("breakpoint outside end state");
	a_delay_trace: assert property (phase_ff == PH_DELAY && !traceHit && !restart
		|=> $stable(delayCnt_ff))
		else $error("delay moved without sample");
	a_timer_run: assert property (!restart ##1 !restart |-> timer_ff == $past(timer_ff) + 32'h1)
		else $error("timer not free running");
	a_wrap_ptr: assert property (traceHit && !restart && wrPtr_ff == `TRACE_LAST
		|=> wrPtr_ff == 11'h0)
		else $error("buffer did not wrap");
	a_mode_reject: assert property (errSet |=> modeErr_ff)
		else $error("mode error lost");
endmodule : bus_trace_breakpoint_sequencer
`default_nettype wire

// ---- tb/target_cpu_model.sv ----
// behavioural target cpu bus that replays the bench's cycles
`timescale 1ns/100ps
`default_nettype none
module target_cpu_model
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire bts_pkg::busCycle_s cmd,
	input  wire logic               haltReq,
	output bts_pkg::busCycle_s      busOut
);
	import bts_pkg::*;
	busCycle_s busOut_ff;
	busCycle_s nxt_busOut;

	// a halted cpu floats its lines, so show inverted values, never stale ones
	always_comb
	begin
		nxt_busOut = busOut_ff;
		nxt_busOut.valid = 1'b0;
		nxt_busOut.kind = KIND_IDLE;
		nxt_busOut.addr = ~busOut_ff.addr;
		nxt_busOut.data = ~busOut_ff.data;
		nxt_busOut.probe = ~busOut_ff.probe;
		if (cmd.valid && !haltReq)
			nxt_busOut = cmd;
	end

	// one bus cycle per clock, launched just after the edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busOut_ff <= '0;
		else
			busOut_ff <= nxt_busOut;
	end

	assign busOut = busOut_ff;
endmodule : target_cpu_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the bus trace and breakpoint sequencer
`timescale 1ns/100ps
`default_nettype none
`include "bts_consts.svh"
module testbench;
	import bts_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdat;
		logic [31:0] exp;
	} row_s;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	busCycle_s   cmd = '0;
	busCycle_s   busIn;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdData;
	logic        haltReq;
	haltWhy_e    haltWhy;
	int          badCount = 0;
	int          nTests = 0;
	logic [31:0] rd;
	logic [31:0] rd2;
	// register reset values, then range limits and an unmapped index
	row_s        rows [16] = '{
		'{1'b0, `REG_CTRL, 32'h0, 32'h0},
		'{1'b0, `REG_DELAY, 32'h0, 32'h0},
		'{1'b0, `REG_MAXTRACE, 32'h0, 32'h0},
		'{1'b0, `REG_ENDSTATE, 32'h0, 32'h0},
		'{1'b0, `REG_LOOP, 32'h0, 32'h1},
		'{1'b0, `REG_TIMEOUT, 32'h0, 32'h0},
		'{1'b0, `REG_STATE0, 32'h0, 32'h0001_0000},
		'{1'b0, 8'h13, 32'h0, 32'h0001_0000},
		'{1'b0, `REG_ACT0, 32'h0, 32'h0},
		'{1'b0, 8'h3f, 32'h0, 32'h0},
		'{1'b1, `REG_DELAY, 32'h7ff, 32'h7ff},
		'{1'b1, `REG_MAXTRACE, 32'h7ff, 32'h7ff},
		'{1'b1, `REG_LOOP, 32'hffff, 32'hffff},
		'{1'b1, `REG_ENDSTATE, 32'h3, 32'h3},
		'{1'b1, 8'h12, 32'hffff_0003, 32'hffff_0003},
		'{1'b1, 8'h3f, 32'h1234, 32'h0}
	};

	bus_trace_breakpoint_sequencer u_bus_trace_breakpoint_sequencer (.clk(clk), .rst_n(rst_n),
		.busIn(busIn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .haltReq(haltReq), .haltWhy(haltWhy));
	target_cpu_model u_target_cpu_model (.clk(clk), .rst_n(rst_n), .cmd(cmd),
		.haltReq(haltReq), .busOut(busIn));

	// 125 mhz clock
	always #4 clk = ~clk;

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : giveVerdict

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp)
		begin
			badCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkReg

	task automatic chkHalt(input logic h, input haltWhy_e w);
		chkReg({29'h0, haltReq, haltWhy}, {29'h0, h, w});
	endtask : chkHalt

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask : rdReg

	task automatic act(input int s, input int n, input actKind_e k, input cycSel_e c,
		input logic [15:0] av, input logic [15:0] am, input logic [31:0] dq);
		logic [7:0] b;
		b = 8'h40 + 8'(s * 16 + n * 4);
		wr(b, {27'h0, c, k});
		wr(b + 8'h01, {am, av});
		wr(b + 8'h02, dq);
	endtask : act

	task automatic bus(input busKind_e k, input logic [15:0] a);
		@(posedge clk);
		cmd <= {1'b1, k, a, a[7:0], 8'h00};
	endtask : bus

	task automatic quiet(input int n);
		@(posedge clk);
		cmd.valid <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : quiet

	// bounded wait; a halt that never comes ends the run
	task automatic expectHalt(input logic h, input haltWhy_e w);
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clk);
			#1;
			if (haltReq === 1'b1)
				break;
		end
		chkHalt(h, w);
		if (h && haltReq !== 1'b1)
			giveVerdict();
	endtask : expectHalt

	task automatic doReset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
	endtask : doReset

	// restart returns to state 0 and loads its event count after configuring
	task automatic go();
		wr(`REG_CTRL, 32'h1);
	endtask : go

	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge clk);
		badCount++;
		giveVerdict();
	end

	initial
	begin
		doReset();
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr(rows[i].addr, rows[i].wdat);
			rdReg(rows[i].addr, rd);
			chkReg(rd, rows[i].exp);
		end
		// address-only state takes slot 3; switching back is refused
		wr(8'h11, 32'h0001_0001);
		act(1, 3, ACT_TRACE, CYC_ALL, 16'h0, 16'h0, 32'h0);
		rdReg(8'h5c, rd);
		chkReg(rd, 32'h1);
		wr(8'h11, 32'h0001_0000);
		rdReg(8'h11, rd);
		chkReg(rd, 32'h0001_0001);
		rdReg(`REG_CTRL, rd);
		chkReg(rd & 32'h8, 32'h8);
		wr(8'h48, 32'h1);
		rdReg(8'h48, rd);
		chkReg(rd, 32'h0);
		wr(`REG_CTRL, 32'h2);
		rdReg(`REG_CTRL, rd);
		chkReg(rd & 32'h8, 32'h0);
		// event needs address and data together, and halts only on a fetch
		doReset();
		act(0, 0, ACT_EVENT, CYC_RD, 16'h1200, 16'hff00, 32'h0000_ff34);
		go();
		bus(KIND_READ, 16'h1235);
		bus(KIND_WRITE, 16'h1234);
		bus(KIND_FETCH, 16'h0100);
		quiet(0);
		expectHalt(1'b0, WHY_NONE);
		bus(KIND_READ, 16'h1234);
		bus(KIND_READ, 16'h0200);
		quiet(0);
		expectHalt(1'b0, WHY_NONE);
		rdReg(`REG_CTRL, rd);
		chkReg({30'h0, rd[5:4]}, 32'h0);
		bus(KIND_FETCH, 16'h0102);
		quiet(0);
		expectHalt(1'b1, WHY_BREAK);
		// delay of two samples; fetches are not traced here
		doReset();
		wr(`REG_DELAY, 32'h2);
		act(0, 0, ACT_EVENT, CYC_WR, 16'h1234, 16'hffff, 32'h0);
		act(0, 1, ACT_TRACE, CYC_RD, 16'h0, 16'h0, 32'h0);
		go();
		bus(KIND_WRITE, 16'h1234);
		bus(KIND_FETCH, 16'h0100);
		quiet(0);
		expectHalt(1'b0, WHY_NONE);
		bus(KIND_READ, 16'h0300);
		bus(KIND_FETCH, 16'h0101);
		quiet(0);
		expectHalt(1'b0, WHY_NONE);
		bus(KIND_READ, 16'h0301);
		bus(KIND_FETCH, 16'h0102);
		quiet(0);
		expectHalt(1'b1, WHY_BREAK);
		rdReg(`REG_TRPTR, rd);
		chkReg(rd, 32'h0002_0002);
		wr(`REG_TRPTR, 32'h0);
		rdReg(`REG_TRSAMPLE, rd);
		chkReg(rd, 32'h0200_0300);
		// max trace of three stops at the following fetch
		doReset();
		wr(`REG_MAXTRACE, 32'h3);
		act(0, 0, ACT_TRACE, CYC_RD, 16'h0, 16'h0, 32'h0);
		go();
		bus(KIND_READ, 16'h0400);
		bus(KIND_READ, 16'h0401);
		bus(KIND_FETCH, 16'h0100);
		quiet(0);
		expectHalt(1'b0, WHY_NONE);
		bus(KIND_READ, 16'h0402);
		bus(KIND_READ, 16'h0403);
		bus(KIND_FETCH, 16'h0101);
		quiet(0);
		expectHalt(1'b1, WHY_FULL);
		// back-to-back samples carry stamps one tick apart
		wr(`REG_TRPTR, 32'h0);
		rdReg(`REG_TRTIME, rd);
		wr(`REG_TRPTR, 32'h1);
		rdReg(`REG_TRTIME, rd2);
		chkReg(rd2 - rd, 32'h1);
		// end state 1, two loops, state 0 needs two events per pass
		doReset();
		wr(`REG_ENDSTATE, 32'h1);
		wr(`REG_LOOP, 32'h2);
		wr(`REG_STATE0, 32'h0002_0000);
		act(0, 0, ACT_EVENT, CYC_WR, 16'h0010, 16'hffff, 32'h0);
		act(1, 0, ACT_EVENT, CYC_WR, 16'h0020, 16'hffff, 32'h0);
		go();
		for (int p = 0; p < 2; p++)
		begin
			bus(KIND_WRITE, 16'h0010);
			quiet(2);
			rdReg(`REG_CTRL, rd);
			chkReg({30'h0, rd[5:4]}, 32'h0);
			bus(KIND_WRITE, 16'h0010);
			quiet(2);
			rdReg(`REG_CTRL, rd);
			chkReg({30'h0, rd[5:4]}, 32'h1);
			bus(KIND_WRITE, 16'h0020);
			bus(KIND_FETCH, 16'h0100);
			quiet(0);
			expectHalt(p == 1, (p == 1) ? WHY_BREAK : WHY_NONE);
		end
		// event count zero never expires
		doReset();
		wr(`REG_STATE0, 32'h0);
		act(0, 0, ACT_EVENT, CYC_ALL, 16'h0, 16'h0, 32'h0);
		go();
		bus(KIND_READ, 16'h0500);
		bus(KIND_FETCH, 16'h0100);
		quiet(0);
		expectHalt(1'b0, WHY_NONE);
		// extended trace: only reads under a matching fetch are kept
		doReset();
		wr(`REG_STATE0, 32'h0001_0002);
		act(0, 0, ACT_TRACE, CYC_RD, 16'h4000, 16'hffff, 32'h0);
		go();
		bus(KIND_FETCH, 16'h4000);
		bus(KIND_READ, 16'h9000);
		bus(KIND_FETCH, 16'h5000);
		bus(KIND_READ, 16'h9001);
		quiet(2);
		rdReg(`REG_TRPTR, rd);
		chkReg(rd, 32'h0001_0001);
		// time-out of 40 cycles halts with the bus idle
		doReset();
		wr(`REG_TIMEOUT, 32'd40);
		go();
		repeat (30) @(posedge clk);
		#1;
		chkHalt(1'b0, WHY_NONE);
		repeat (4) @(posedge clk);
		expectHalt(1'b1, WHY_TIMEOUT);
		// timer keeps counting while halted; reads sample two edges apart
		rdReg(`REG_TIMER, rd);
		rdReg(`REG_TIMER, rd2);
		chkReg(rd2 - rd, 32'h2);
		giveVerdict();
	end
endmodule : testbench
`default_nettype wire
